// ---- rtl/armc_dac_chan.sv ----
// one margining dac channel: clipping and glitch-free buffer enable
`timescale 1ns/1ps
module armc_dac_chan import armc_pkg::*; #(
   parameter int SETTLE = SETTLE_CYC
) (
   // clock and reset
   input  wire logic              clk,
   input  wire logic              srst,
   // settings
   input  wire logic              en,
   input  wire logic [CODE_W-1:0] code,
   input  wire logic [1:0]        range,
   input  wire logic [CODE_W-1:0] up_lim,
   input  wire logic [CODE_W-1:0] lo_lim,
   // to the analog dac
   output armc_dac_s              dac
);
   typedef enum logic [1:0] {ST_OFF, ST_FOLLOW, ST_ON} armc_dst_e;
   armc_dst_e         st_r, st_nxt;
   logic [15:0]       cnt_r, cnt_nxt;
   armc_dac_s         dac_r, dac_nxt;
   logic              inverted;
   logic [CODE_W-1:0] eff;

   always_comb begin
      inverted = lo_lim > up_lim;
      if (code < lo_lim)
         eff = lo_lim;
      else if (code > up_lim)
         eff = up_lim;
      else
         eff = code;
      st_nxt  = st_r;
      cnt_nxt = cnt_r;
      if (!en || inverted) begin
         st_nxt  = ST_OFF;
         cnt_nxt = '0;
      end else begin
         unique case (st_r)
            ST_OFF: begin
               st_nxt  = ST_FOLLOW;
               cnt_nxt = '0;
            end
            ST_FOLLOW: begin
               cnt_nxt = cnt_r + 16'h0001;
               if (cnt_r == 16'(SETTLE - 1))
                  st_nxt = ST_ON;
            end
            ST_ON: st_nxt = ST_ON;
            // the spare code of the two-bit state falls back to off
            default: st_nxt = ST_OFF;
         endcase
      end
      dac_nxt.follow  = (st_nxt != ST_OFF);
      dac_nxt.sel_dac = (st_nxt == ST_ON);
      dac_nxt.drive   = (st_nxt == ST_ON);
      dac_nxt.range   = range;
      dac_nxt.code    = eff;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         st_r  <= ST_OFF;
         cnt_r <= '0;
         dac_r <= '{follow: 1'b0, sel_dac: 1'b0, drive: 1'b0, range: 2'h0, code: DAC_MID};
      end else begin
         st_r  <= st_nxt;
         cnt_r <= cnt_nxt;
         dac_r <= dac_nxt;
      end
   end

   assign dac = dac_r;
endmodule

// ---- rtl/armc_pkg.sv ----
// shared constants and types for the readback and margin control block
// Overview of operation
// - convert chosen subset of eight channels in turn
// - single-pass or continuous round-robin modes
// - averaging runs sixteen passes before results
// - results update only at cycle end
// - codes unsigned, zero to 4095 full scale
// - one limit per channel, max or min
// - limit crossing raises warning to status, engine
// - start from host write or engine state
// - about 500 us per selected channel
// - 8-bit dac code, midcode 0x7F
// - output linear in code about midcode
// - range select picks one of four offsets
// - swing plus 128, minus 127 codes
// - four dacs, own code and enable
// - host writes code, dac output follows
// - buffer follows pin before driving dac
// - code clipped to limits, tristate if inverted
package armc_pkg;
   localparam int          NCH        = 8;
   localparam int          NDAC       = 4;
   localparam int          ADC_W      = 12;
   localparam int          CODE_W     = 8;
   localparam int          AVG_PASSES = 16;
   localparam int          AVG_SHIFT  = 4;
   localparam int          CLK_MHZ    = 20;
   localparam int          CH_TIME_US = 500;
   localparam int          CH_CYCLES  = CH_TIME_US * CLK_MHZ;
   localparam int          SETTLE_CYC = 16;
   localparam logic [7:0]  DAC_MID    = 8'h7F;
   localparam logic [11:0] ADC_FULL   = 12'hFFF;
   // register offsets (word index on the plain port)
   localparam logic [5:0]  A_CTRL     = 6'h00; // [0]start [1]cont [2]avg [3]stop
   localparam logic [5:0]  A_CHSEL    = 6'h01;
   localparam logic [5:0]  A_LIMSENSE = 6'h02; // 1 = maximum threshold
   localparam logic [5:0]  A_STATUS   = 6'h03; // [0]busy [15:8]warnings
   localparam logic [5:0]  A_DACEN    = 6'h04;
   localparam logic [5:0]  A_RESULT0  = 6'h08;
   localparam logic [5:0]  A_LIMIT0   = 6'h10;
   localparam logic [5:0]  A_DAC0     = 6'h18; // [7:0]code [9:8]range
   localparam logic [5:0]  A_UPLIM0   = 6'h1C;
   localparam logic [5:0]  A_LOLIM0   = 6'h20;
   localparam int          CTRL_START = 0;
   localparam int          CTRL_CONT  = 1;
   localparam int          CTRL_AVG   = 2;
   localparam int          CTRL_STOP  = 3;
   localparam logic [7:0]  UPLIM_RST  = 8'hFF;
   localparam logic [7:0]  LOLIM_RST  = 8'h00;
   typedef struct packed {
      logic        follow;   // buffer powered, tracking pin
      logic        sel_dac;  // buffer input switched to dac
      logic        drive;    // output stage on
      logic [1:0]  range;
      logic [7:0]  code;
   } armc_dac_s;
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [5:0]  addr;
      logic [15:0] wdata;
   } armc_bus_s;
endpackage

// ---- rtl/armc_top.sv ----
// adc round-robin readback, limit warnings and margin dac registers
//
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
module armc_top import armc_pkg::*; #(
   parameter int CH_CYC = CH_CYCLES,
   parameter int SETTLE = SETTLE_CYC
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             srst,
   // register port
   input  wire logic [5:0]       addr,
   input  wire logic [15:0]      wdata,
   input  wire logic             wr,
   input  wire logic             rd,
   output logic      [15:0]      rdata,
   // sequencing engine
   input  wire logic             eng_start,
   output logic      [NCH-1:0]   warn,
   // converter
   output logic      [2:0]       mux_sel,
   output logic                  adc_start,
   input  wire logic             adc_done,
   input  wire logic [ADC_W-1:0] adc_code,
   // margining dacs
   output armc_dac_s             dac [NDAC]
);
   typedef enum logic [1:0] {S_IDLE, S_CONV, S_WAIT, S_NEXT} armc_st_e;

   armc_st_e            st_r, st_nxt;
   logic [NCH-1:0]      chsel_r, chsel_nxt;
   logic [NCH-1:0]      sense_r, sense_nxt;
   logic                cont_r, cont_nxt, avg_r, avg_nxt;
   logic [NDAC-1:0]     dacen_r, dacen_nxt;
   logic [ADC_W-1:0]    res_r [NCH];
   logic [ADC_W-1:0]    res_nxt [NCH];
   logic [ADC_W-1:0]    lim_r [NCH];
   logic [ADC_W-1:0]    lim_nxt [NCH];
   logic [ADC_W+3:0]    acc_r [NCH];
   logic [ADC_W+3:0]    acc_nxt [NCH];
   logic [9:0]          dcfg_r [NDAC];
   logic [9:0]          dcfg_nxt [NDAC];
   logic [7:0]          uplim_r [NDAC];
   logic [7:0]          uplim_nxt [NDAC];
   logic [7:0]          lolim_r [NDAC];
   logic [7:0]          lolim_nxt [NDAC];
   logic [NCH-1:0]      warn_r, warn_nxt;
   logic [2:0]          ch_r, ch_nxt;
   logic [3:0]          pass_r, pass_nxt;
   logic [23:0]         tmr_r, tmr_nxt;
   logic                start_r, start_nxt;
   logic [15:0]         rdata_r, rdata_nxt;
   logic [1:0]          eng_sync_r;
   logic                eng_prev_r;
   logic                eng_rise;
   logic                done_r;
   logic [ADC_W-1:0]    code_r;
   logic [3:0]          last_pass;
   logic                go;
   logic                last_ch;
   logic [2:0]          nxt_ch;
   logic                found;

   assign eng_rise = eng_sync_r[1] & ~eng_prev_r;
   assign go = (wr && addr == A_CTRL && wdata[CTRL_START]) || eng_rise;
   assign last_pass = avg_r ? 4'(AVG_PASSES - 1) : 4'h0;

   // next selected channel above the current one, in turn
   always_comb begin
      nxt_ch = ch_r;
      found  = 1'b0;
      for (int i = 1; i < NCH; i++) begin
         if (!found && chsel_r[3'(ch_r + 3'(i))]) begin
            nxt_ch = 3'(ch_r + 3'(i));
            found  = 1'b1;
         end
      end
      last_ch = !found || (nxt_ch <= ch_r);
   end

   always_comb begin
      chsel_nxt = chsel_r;
      sense_nxt = sense_r;
      cont_nxt  = cont_r;
      avg_nxt   = avg_r;
      dacen_nxt = dacen_r;
      res_nxt   = res_r;
      lim_nxt   = lim_r;
      acc_nxt   = acc_r;
      dcfg_nxt  = dcfg_r;
      uplim_nxt = uplim_r;
      lolim_nxt = lolim_r;
      warn_nxt  = warn_r;
      st_nxt    = st_r;
      ch_nxt    = ch_r;
      pass_nxt  = pass_r;
      tmr_nxt   = tmr_r;
      start_nxt = 1'b0;
      rdata_nxt = 16'h0000;
      if (wr) begin
         unique case (addr)
            A_CTRL: begin
               cont_nxt = wdata[CTRL_CONT];
               avg_nxt  = wdata[CTRL_AVG];
            end
            A_CHSEL:    chsel_nxt = wdata[NCH-1:0];
            A_LIMSENSE: sense_nxt = wdata[NCH-1:0];
            A_DACEN:    dacen_nxt = wdata[NDAC-1:0];
            default: begin
               if (addr[5:3] == A_LIMIT0[5:3])
                  lim_nxt[addr[2:0]] = wdata[ADC_W-1:0];
               if (addr[5:2] == A_DAC0[5:2])
                  dcfg_nxt[addr[1:0]] = wdata[9:0];
               if (addr[5:2] == A_UPLIM0[5:2])
                  uplim_nxt[addr[1:0]] = wdata[7:0];
               if (addr[5:2] == A_LOLIM0[5:2])
                  lolim_nxt[addr[1:0]] = wdata[7:0];
            end
         endcase
      end
      // reads only sample state, never steer the sequencer
      if (rd) begin
         unique case (addr)
            A_CTRL:     rdata_nxt = {13'h0000, avg_r, cont_r, 1'b0};
            A_CHSEL:    rdata_nxt = {8'h00, chsel_r};
            A_LIMSENSE: rdata_nxt = {8'h00, sense_r};
            A_STATUS:   rdata_nxt = {warn_r, 7'h00, st_r != S_IDLE};
            A_DACEN:    rdata_nxt = {12'h000, dacen_r};
            default: begin
               if (addr[5:3] == A_RESULT0[5:3])
                  rdata_nxt = {4'h0, res_r[addr[2:0]]};
               if (addr[5:3] == A_LIMIT0[5:3])
                  rdata_nxt = {4'h0, lim_r[addr[2:0]]};
               if (addr[5:2] == A_DAC0[5:2])
                  rdata_nxt = {6'h00, dcfg_r[addr[1:0]]};
               if (addr[5:2] == A_UPLIM0[5:2])
                  rdata_nxt = {8'h00, uplim_r[addr[1:0]]};
               if (addr[5:2] == A_LOLIM0[5:2])
                  rdata_nxt = {8'h00, lolim_r[addr[1:0]]};
            end
         endcase
      end
      unique case (st_r)
         S_IDLE: begin
            if (go && chsel_r != '0) begin
               ch_nxt   = 3'h0;
               for (int i = NCH - 1; i >= 0; i--)
                  if (chsel_r[i])
                     ch_nxt = 3'(i);
               pass_nxt = 4'h0;
               for (int i = 0; i < NCH; i++)
                  acc_nxt[i] = '0;
               st_nxt = S_CONV;
            end
         end
         S_CONV: begin
            start_nxt = 1'b1;
            tmr_nxt   = 24'(CH_CYC - 1);
            st_nxt    = S_WAIT;
         end
         S_WAIT: begin
            if (tmr_r != 24'h000000)
               tmr_nxt = tmr_r - 24'h000001;
            if (done_r) begin
               acc_nxt[ch_r] = acc_r[ch_r] + 16'(code_r);
            end
            if (tmr_r == 24'h000000)
               st_nxt = S_NEXT;
         end
         S_NEXT: begin
            ch_nxt = nxt_ch;
            st_nxt = S_CONV;
            if (last_ch) begin
               pass_nxt = pass_r + 4'h1;
               if (pass_r == last_pass) begin
                  pass_nxt = 4'h0;
                  for (int i = 0; i < NCH; i++) begin
                     if (chsel_r[i]) begin
                        res_nxt[i] = avg_r ? acc_r[i][ADC_W+3:AVG_SHIFT]
                                           : acc_r[i][ADC_W-1:0];
                        warn_nxt[i] = sense_r[i] ? (res_nxt[i] > lim_r[i])
                                                 : (res_nxt[i] < lim_r[i]);
                     end
                     acc_nxt[i] = '0;
                  end
                  if (!cont_r)
                     st_nxt = S_IDLE;
               end
            end
         end
      endcase
      if (wr && addr == A_CTRL && wdata[CTRL_STOP])
         st_nxt = S_IDLE;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         st_r       <= S_IDLE;
         chsel_r    <= '0;
         sense_r    <= '0;
         cont_r     <= 1'b0;
         avg_r      <= 1'b0;
         dacen_r    <= '0;
         warn_r     <= '0;
         ch_r       <= 3'h0;
         pass_r     <= 4'h0;
         tmr_r      <= 24'h000000;
         start_r    <= 1'b0;
         rdata_r    <= 16'h0000;
         eng_sync_r <= 2'h0;
         eng_prev_r <= 1'b0;
         done_r     <= 1'b0;
         code_r     <= '0;
         for (int i = 0; i < NCH; i++) begin
            res_r[i] <= '0;
            lim_r[i] <= '0;
            acc_r[i] <= '0;
         end
         for (int i = 0; i < NDAC; i++) begin
            dcfg_r[i]  <= {2'h0, DAC_MID};
            uplim_r[i] <= UPLIM_RST;
            lolim_r[i] <= LOLIM_RST;
         end
      end else begin
         st_r       <= st_nxt;
         chsel_r    <= chsel_nxt;
         sense_r    <= sense_nxt;
         cont_r     <= cont_nxt;
         avg_r      <= avg_nxt;
         dacen_r    <= dacen_nxt;
         warn_r     <= warn_nxt;
         ch_r       <= ch_nxt;
         pass_r     <= pass_nxt;
         tmr_r      <= tmr_nxt;
         start_r    <= start_nxt;
         rdata_r    <= rdata_nxt;
         eng_sync_r <= {eng_sync_r[0], eng_start};
         eng_prev_r <= eng_sync_r[1];
         done_r     <= adc_done;
         code_r     <= adc_code;
         res_r      <= res_nxt;
         lim_r      <= lim_nxt;
         acc_r      <= acc_nxt;
         dcfg_r     <= dcfg_nxt;
         uplim_r    <= uplim_nxt;
         lolim_r    <= lolim_nxt;
      end
   end

   assign rdata     = rdata_r;
   assign warn      = warn_r;
   assign mux_sel   = ch_r;
   assign adc_start = start_r;

   for (genvar g = 0; g < NDAC; g++) begin : g_dac
      armc_dac_chan #(.SETTLE(SETTLE)) u_dac (
         .clk    (clk),
         .srst   (srst),
         .en     (dacen_r[g]),
         .code   (dcfg_r[g][7:0]),
         .range  (dcfg_r[g][9:8]),
         .up_lim (uplim_r[g]),
         .lo_lim (lolim_r[g]),
         .dac    (dac[g])
      );
   end
endmodule

// ---- tb/armc_adc_model.sv ----
// behavioural converter model answering start pulses after a set delay
`timescale 1ns/1ps
module armc_adc_model import armc_pkg::*; (
   // clock and delay setting
   input  wire logic             clk,
   input  wire logic [7:0]       dly,
   // converter handshake
   input  wire logic             adc_start,
   input  wire logic [2:0]       mux_sel,
   output logic                  adc_done,
   output logic      [ADC_W-1:0] adc_code
);
   logic [3:0]       cnt [NCH] = '{default: 4'h0};
   logic [2:0]       ch        = 3'h0;
   int               t         = 0;
   logic             done_q    = 1'b0;
   logic [ADC_W-1:0] code_q    = 12'h000;
   // code walks with a per-channel count so averaging is visible
   always @(posedge clk) begin
      done_q <= (t == 1) && !adc_start;
      code_q <= ((t == 1) && !adc_start) ? {ch, cnt[ch], 5'h05} : ~code_q;
      if (adc_start) begin
         ch <= mux_sel;
         t <= int'(dly);
      end else if (t > 0) begin
         t <= t - 1;
         if (t == 1) begin
            cnt[ch] <= cnt[ch] + 4'h1;
         end
      end
   end
   assign adc_done = done_q;
   assign adc_code = code_q;
endmodule

// ---- tb/armc_top_properties.sv ----
// concurrent checks on the readback and margin block ports
`timescale 1ns/1ps
module armc_top_properties import armc_pkg::*; #(
   parameter int CH_CYC = CH_CYCLES,
   parameter int SETTLE = SETTLE_CYC
) (
   // clock, reset and register port
   input wire logic             clk,
   input wire logic             srst,
   input wire logic [5:0]       addr,
   input wire logic [15:0]      wdata,
   input wire logic             wr,
   input wire logic             rd,
   input wire logic [15:0]      rdata,
   // engine, converter and dacs
   input wire logic             eng_start,
   input wire logic [NCH-1:0]   warn,
   input wire logic [2:0]       mux_sel,
   input wire logic             adc_start,
   input wire logic             adc_done,
   input wire logic [ADC_W-1:0] adc_code,
   input armc_dac_s             dac [NDAC]
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   logic [15:0] gap_r;
   logic [15:0] gap_nxt;
   // saturating so a long idle never wraps into a false short gap
   always_comb begin
      gap_nxt = (gap_r == 16'hFFFF) ? gap_r : gap_r + 16'h0001;
      if (adc_start) begin
         gap_nxt = 16'h0001;
      end
   end
   always_ff @(posedge clk) begin
      gap_r <= srst ? 16'hFFFF : gap_nxt;
   end
   property p_pulse; adc_start |=> !adc_start; endproperty
   property p_mux_hold; adc_start |=> $stable(mux_sel) [*8]; endproperty
   property p_gap; adc_start |-> gap_r >= CH_CYC; endproperty
   property p_warn_hold; adc_start |=> $stable(warn) [*8]; endproperty
   property p_reset_vals; $fell(srst) |-> rdata == 16'h0000 && warn == 8'h00; endproperty
   a_pulse: assert property (p_pulse) else $error("start pulse too long");
   a_mux_hold: assert property (p_mux_hold) else $error("channel moved mid conversion");
   a_gap: assert property (p_gap) else $error("channel slot too short");
   a_warn_hold: assert property (p_warn_hold) else $error("warning moved mid cycle");
   a_reset_vals: assert property (p_reset_vals) else $error("bad reset outputs");
   for (genvar i = 0; i < NDAC; i++) begin : g_dac
      sequence s_follow_only; dac[i].follow && !dac[i].drive; endsequence
      property p_follow_first; $rose(dac[i].follow) |-> s_follow_only [*3]; endproperty
      property p_drive_pair; dac[i].drive |-> dac[i].sel_dac && dac[i].follow; endproperty
      property p_drive_late; $rose(dac[i].drive) |-> $past(dac[i].follow); endproperty
      property p_reset_dac; $fell(srst) |-> dac[i].code == DAC_MID && !dac[i].follow; endproperty
      a_follow_first: assert property (p_follow_first) else $error("drove too early");
      a_drive_pair: assert property (p_drive_pair) else $error("drive without follow");
      a_drive_late: assert property (p_drive_late) else $error("drive before follow");
      a_reset_dac: assert property (p_reset_dac) else $error("dac reset wrong");
   end
endmodule
bind armc_top armc_top_properties #(.CH_CYC(CH_CYC), .SETTLE(SETTLE)) armc_top_properties_inst (
   .clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
   .eng_start(eng_start), .warn(warn), .mux_sel(mux_sel), .adc_start(adc_start),
   .adc_done(adc_done), .adc_code(adc_code), .dac(dac));

// ---- tb/armc_top_test.sv ----
// self-checking bench for the readback and margin block
`timescale 1ns/1ps
module armc_top_test import armc_pkg::*; ();
   localparam int    CHC = 20;
   localparam int    STL = 4;
   logic             clk, srst, wr, rd, eng_start, adc_start, adc_done;
   logic [5:0]       addr;
   logic [15:0]      wdata, rdata;
   logic [NCH-1:0]   warn;
   logic [2:0]       mux_sel;
   logic [ADC_W-1:0] adc_code;
   logic [7:0]       dly;
   armc_dac_s        dac [NDAC];
   int               failures, checks;
   armc_top #(.CH_CYC(CHC), .SETTLE(STL)) armc_top_inst (
      .clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .eng_start(eng_start), .warn(warn), .mux_sel(mux_sel), .adc_start(adc_start),
      .adc_done(adc_done), .adc_code(adc_code), .dac(dac));
   armc_adc_model armc_adc_model_inst (.clk(clk), .dly(dly), .adc_start(adc_start),
      .mux_sel(mux_sel), .adc_done(adc_done), .adc_code(adc_code));
   initial clk = 1'b0;
   always #25 clk = ~clk;
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr_reg(input logic [5:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [5:0] a, output logic [15:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic rd_chk(input logic [5:0] a, input logic [15:0] exp);
      logic [15:0] d;
      rd_reg(a, d);
      chk(d, exp);
   endtask
   // polling status also shows that reads leave the sequencer alone
   task automatic wait_idle;
      logic [15:0] s;
      s = 16'h0001;
      for (int k = 0; k < 2000 && s[0] !== 1'b0; k++) rd_reg(A_STATUS, s);
      chk({15'h0000, s[0]}, 16'h0000);
   endtask
   task automatic t_reset;
      rd_chk(A_UPLIM0, 16'h00FF);
      rd_chk(A_LOLIM0, 16'h0000);
      rd_chk(A_DAC0, 16'h007F);
      rd_chk(A_RESULT0, 16'h0000);
      wr_reg(A_STATUS, 16'hFFFF);
      rd_chk(A_STATUS, 16'h0000);
      wr_reg(6'h3F, 16'h1234);
      rd_chk(6'h3F, 16'h0000);
   endtask
   task automatic t_single;
      // the answer has to land inside the channel slot or it is dropped
      dly <= 8'h10;
      wr_reg(A_CHSEL, 16'h0081);
      wr_reg(A_LIMSENSE, 16'h0001);
      wr_reg(A_LIMIT0, 16'h0100);
      wr_reg(A_LIMIT0 + 6'h07, 16'h0FFF);
      wr_reg(A_CTRL, 16'h0001);
      rd_chk(A_RESULT0, 16'h0000);
      wait_idle();
      rd_chk(A_RESULT0, 16'h0005);
      rd_chk(A_RESULT0 + 6'h07, 16'h0E05);
      chk({8'h00, warn}, 16'h0080);
      rd_chk(A_STATUS, 16'h8000);
   endtask
   task automatic t_avg;
      dly <= 8'h01;
      wr_reg(A_LIMIT0, 16'h00F0);
      wr_reg(A_CTRL, 16'h0005);
      rd_chk(A_RESULT0, 16'h0005);
      wait_idle();
      rd_chk(A_RESULT0, 16'h00F5);
      rd_chk(A_RESULT0 + 6'h07, 16'h0EF5);
      rd_chk(A_STATUS, 16'h8100);
   endtask
   task automatic t_cont;
      logic [15:0] s;
      int          n;
      n = 0;
      wr_reg(A_CTRL, 16'h0002);
      eng_start <= 1'b1;
      for (int k = 0; k < 400 && n < 6; k++) begin
         @(posedge clk);
         #1 if (adc_start === 1'b1) n++;
      end
      chk(16'(n), 16'h0006);
      rd_reg(A_STATUS, s);
      chk({15'h0000, s[0]}, 16'h0001);
      wr_reg(A_CTRL, 16'h0008);
      eng_start <= 1'b0;
      rd_reg(A_STATUS, s);
      chk({15'h0000, s[0]}, 16'h0000);
   endtask
   task automatic t_dac;
      wr_reg(A_DACEN, 16'h0000);
      wr_reg(A_UPLIM0 + 6'h01, 16'h0090);
      wr_reg(A_LOLIM0 + 6'h01, 16'h0020);
      wr_reg(A_DAC0 + 6'h01, 16'h03A0);
      wr_reg(A_DAC0 + 6'h02, 16'h0155);
      repeat (2) @(posedge clk);
      #1 chk({6'h00, dac[1].range, dac[1].code}, 16'h0390);
      chk({6'h00, dac[2].range, dac[2].code}, 16'h0155);
      chk({13'h0, dac[1].follow, dac[1].sel_dac, dac[1].drive}, 16'h0000);
      wr_reg(A_DACEN, 16'h0002);
      repeat (2) @(posedge clk);
      #1 chk({13'h0, dac[1].follow, dac[1].sel_dac, dac[1].drive}, 16'h0004);
      repeat (STL + 2) @(posedge clk);
      #1 chk({13'h0, dac[1].follow, dac[1].sel_dac, dac[1].drive}, 16'h0007);
      chk({7'h00, dac[0].follow, dac[0].code}, 16'h007F);
      wr_reg(A_DAC0 + 6'h01, 16'h0310);
      repeat (2) @(posedge clk);
      #1 chk({8'h00, dac[1].code}, 16'h0020);
      wr_reg(A_LOLIM0 + 6'h01, 16'h00A0);
      repeat (2) @(posedge clk);
      #1 chk({13'h0, dac[1].follow, dac[1].sel_dac, dac[1].drive}, 16'h0000);
   endtask
   // host closed loop: read the margined output back, step the code until on target
   task automatic t_loop;
      logic [7:0] c;
      c = 8'h40;
      wr_reg(A_LOLIM0 + 6'h01, 16'h0020);
      repeat (2) @(posedge clk);
      #1;
      for (int k = 0; k < 32 && dac[1].code !== 8'h80; k++) begin
         c = (dac[1].code < 8'h80) ? c + 8'h08 : c - 8'h08;
         wr_reg(A_DAC0 + 6'h01, {8'h03, c});
         repeat (2) @(posedge clk);
         #1;
      end
      chk({8'h00, dac[1].code}, 16'h0080);
      chk({13'h0, dac[1].follow, dac[1].sel_dac, dac[1].drive}, 16'h0007);
   endtask
   task automatic results;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      #(20000 * 50);
      failures++;
      results();
   end
   initial begin
      srst = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      addr = 6'h00;
      wdata = 16'h0000;
      eng_start = 1'b0;
      dly = 8'h01;
      failures = 0;
      checks = 0;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      t_reset();
      t_single();
      t_avg();
      t_cont();
      t_dac();
      t_loop();
      results();
   end
endmodule
